// [logic/mib_pkg.sv]
package mib_pkg;
   // ****************************************
   // Mode register addresses
   // ****************************************
   localparam logic [7:0] MR_ADDR_INFO = 8'h00;
   localparam logic [7:0] MR_ADDR_FEAT = 8'h01;
   localparam logic [7:0] MR_ADDR_CAL = 8'h0A;
   localparam logic [7:0] UNDEF_RDATA = 8'hA5;
   // ****************************************
   // Field codes
   // ****************************************
   localparam logic [2:0] INFO_RSVD = 3'h0;
   localparam logic INFO_TYPE_S4 = 1'h0;
   localparam logic INFO_DNV_NONE = 1'h0;
   localparam logic [1:0] RZQ_NOT_RUN = 2'h0;
   localparam logic [1:0] RZQ_SUPPLY_OR_FLOAT = 2'h1;
   localparam logic [1:0] RZQ_GROUND = 2'h2;
   localparam logic [1:0] RZQ_PASSED = 2'h3;
   localparam logic [1:0] PIN_RESISTOR = 2'h0;
   localparam logic [1:0] PIN_SUPPLY = 2'h1;
   localparam logic [1:0] PIN_FLOAT = 2'h2;
   localparam logic [1:0] PIN_GROUND = 2'h3;
   localparam logic [2:0] BL4 = 3'h2;
   localparam logic [2:0] BL8 = 3'h3;
   localparam logic [2:0] BL16 = 3'h4;
   localparam logic [3:0] MASK_BL4 = 4'h3;
   localparam logic [3:0] MASK_BL8 = 4'h7;
   localparam logic [3:0] MASK_BL16 = 4'hF;
   localparam logic [3:0] NWR_OFFSET = 4'h2;
   localparam logic [8:0] NWR_MIN = 9'h003;
   localparam logic [8:0] NWR_MAX = 9'h008;
   localparam logic [7:0] FEAT_RESET = 8'h22;
   // ****************************************
   // Column limits for no-wrap starts
   // ****************************************
   localparam logic BUS_X16 = 1'h1;
   localparam logic [9:0] COL_FULL_X16 = 10'h3FE;
   localparam logic [9:0] COL_SUB_X16 = 10'h1FE;
   // ****************************************
   // Timing
   // ****************************************
   localparam int CLK_PERIOD_NS = 10;
   localparam int AUTO_INIT_NS = 1000;
   localparam int CAL_NS = 360;
   localparam logic [15:0] AUTO_INIT_CYCLES = 16'((AUTO_INIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [7:0] CAL_CYCLES = 8'((CAL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
   localparam logic [8:0] CLK_NS9 = 9'(CLK_PERIOD_NS);
   // ****************************************
   // Controller registers
   // ****************************************
   localparam logic [3:0] REG_MR_CMD = 4'h0;
   localparam logic [3:0] REG_STATUS = 4'h4;
   localparam logic [3:0] REG_BURST = 4'h8;
   localparam logic [3:0] REG_FEATURE = 4'hC;
   localparam logic [31:0] WORD_ZERO = 32'h0000_0000;
   typedef enum logic [1:0] {CTL_IDLE, CTL_MR_WAIT, CTL_BURST_WAIT} mib_state_t;
endpackage

// [logic/mib_link_if.sv]
`timescale 1ns/100ps
interface mib_link_if;
   logic mr_valid;
   logic mr_write;
   logic [7:0] mr_addr;
   logic [7:0] mr_wdata;
   logic mr_ack;
   logic [7:0] mr_rdata;
   logic dqs;
   logic col_valid;
   logic col_write;
   logic col_ap;
   logic [9:1] col_addr;
   logic beat_valid;
   logic [9:0] beat_col;
   logic burst_done;
   logic precharge_start;
   modport dev (
      input mr_valid, mr_write, mr_addr, mr_wdata, col_valid, col_write, col_ap, col_addr,
      output mr_ack, mr_rdata, dqs, beat_valid, beat_col, burst_done, precharge_start
   );
   modport ctl (
      output mr_valid, mr_write, mr_addr, mr_wdata, col_valid, col_write, col_ap, col_addr,
      input mr_ack, mr_rdata, dqs, beat_valid, beat_col, burst_done, precharge_start
   );
endinterface

// [logic/mib_ctl.sv]
`timescale 1ns/100ps
module mib_ctl (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic [31:0] hrdata,
   output logic hresp,
   mib_link_if.ctl link
);
   mib_pkg::mib_state_t state_q;
   logic wr_pend_q;
   logic [3:0] addr_q;
   logic [31:0] hrdata_q;
   logic [7:0] last_rdata_q;
   logic err_q;
   logic mr_valid_q, mr_write_q, col_valid_q, col_write_q, col_ap_q;
   logic [7:0] mr_addr_q, mr_wdata_q;
   logic [9:1] col_addr_q;
   logic cfg_nw_q;
   logic [2:0] bl;
   logic [8:0] cyc;
   logic feat_ok, burst_ok, idle, acc_mr, acc_col, acc_feat, refuse;

   // ****************************************
   // Bus slave, zero wait states
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_pend_q <= 1'h0;
         addr_q <= 4'h0;
      end
      else
      begin
         wr_pend_q <= hsel && hready && htrans[1] && hwrite;
         if (hsel && hready && htrans[1])
            addr_q <= haddr[3:0];
      end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         hrdata_q <= mib_pkg::WORD_ZERO;
      else if (hsel && hready && htrans[1] && !hwrite)
         hrdata_q <= (haddr[3:0] == mib_pkg::REG_STATUS) ?
                     {22'h00_0000, err_q, !idle, last_rdata_q} : mib_pkg::WORD_ZERO;

   assign hreadyout = 1'h1;
   assign hresp = 1'h0;
   assign hrdata = hrdata_q;

   // ****************************************
   // Order checks
   // ****************************************
   always_comb
   begin
      bl = hwdata[2:0];
      cyc = 9'((9'(hwdata[15:8]) + mib_pkg::CLK_NS9 - 9'h001) / mib_pkg::CLK_NS9);
      if (cyc < mib_pkg::NWR_MIN)
         cyc = mib_pkg::NWR_MIN;
      feat_ok = (bl == mib_pkg::BL4 || bl == mib_pkg::BL8 || bl == mib_pkg::BL16)
                && !(hwdata[4] && bl != mib_pkg::BL4)
                && !(hwdata[3] && bl == mib_pkg::BL16)
                && cyc <= mib_pkg::NWR_MAX;
      // Bit 0 never reaches the device, so an odd start is judged as the even one below it
      burst_ok = !(cfg_nw_q && ({hwdata[9:1], 1'h0} == mib_pkg::COL_SUB_X16 ||
                   (mib_pkg::BUS_X16 && {hwdata[9:1], 1'h0} == mib_pkg::COL_FULL_X16)));
      idle = state_q == mib_pkg::CTL_IDLE;
      acc_mr = wr_pend_q && idle && addr_q == mib_pkg::REG_MR_CMD;
      acc_col = wr_pend_q && idle && addr_q == mib_pkg::REG_BURST && burst_ok;
      acc_feat = wr_pend_q && idle && addr_q == mib_pkg::REG_FEATURE && feat_ok;
      refuse = wr_pend_q && addr_q != mib_pkg::REG_STATUS && !(acc_mr || acc_col || acc_feat);
   end

   // Refusals stick until software writes the status word
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         err_q <= 1'h0;
      else if (refuse)
         err_q <= 1'h1;
      else if (wr_pend_q && addr_q == mib_pkg::REG_STATUS)
         err_q <= 1'h0;

   // ****************************************
   // Link master
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         state_q <= mib_pkg::CTL_IDLE;
         mr_valid_q <= 1'h0;
         mr_write_q <= 1'h0;
         mr_addr_q <= 8'h00;
         mr_wdata_q <= 8'h00;
         col_valid_q <= 1'h0;
         col_write_q <= 1'h0;
         col_ap_q <= 1'h0;
         col_addr_q <= 9'h000;
         cfg_nw_q <= 1'h0;
         last_rdata_q <= 8'h00;
      end
      else
      begin
         mr_valid_q <= 1'h0;
         col_valid_q <= 1'h0;
         unique case (state_q)
            mib_pkg::CTL_IDLE:
               if (acc_mr)
               begin
                  mr_valid_q <= 1'h1;
                  mr_addr_q <= hwdata[7:0];
                  mr_wdata_q <= hwdata[15:8];
                  mr_write_q <= hwdata[16];
                  state_q <= mib_pkg::CTL_MR_WAIT;
               end
               else if (acc_feat)
               begin
                  mr_valid_q <= 1'h1;
                  mr_write_q <= 1'h1;
                  mr_addr_q <= mib_pkg::MR_ADDR_FEAT;
                  mr_wdata_q <= {3'(cyc - 9'(mib_pkg::NWR_OFFSET)), hwdata[4:0]};
                  cfg_nw_q <= hwdata[4];
                  state_q <= mib_pkg::CTL_MR_WAIT;
               end
               else if (acc_col)
               begin
                  col_valid_q <= 1'h1;
                  col_addr_q <= hwdata[9:1];
                  col_write_q <= hwdata[10];
                  col_ap_q <= hwdata[11];
                  state_q <= mib_pkg::CTL_BURST_WAIT;
               end
            mib_pkg::CTL_MR_WAIT:
               if (link.mr_ack)
               begin
                  if (!mr_write_q)
                     last_rdata_q <= link.mr_rdata;
                  state_q <= mib_pkg::CTL_IDLE;
               end
            mib_pkg::CTL_BURST_WAIT:
               if (link.burst_done)
                  state_q <= mib_pkg::CTL_IDLE;
            default:
               state_q <= mib_pkg::CTL_IDLE;
         endcase
      end

   assign link.mr_valid = mr_valid_q;
   assign link.mr_write = mr_write_q;
   assign link.mr_addr = mr_addr_q;
   assign link.mr_wdata = mr_wdata_q;
   assign link.col_valid = col_valid_q;
   assign link.col_write = col_write_q;
   assign link.col_ap = col_ap_q;
   assign link.col_addr = col_addr_q;
endmodule

// [logic/mib_dev.sv]
// How it works
// - Info bit 0 high while auto-init runs
// - Info bits 1 and 2 read zero
// - Bits 4:3 carry resistor self-test result
// - Self-test result updates when calibration ends
// - Pin tied to supply reports 01
// - Results 01/10 lock out further calibration
// - No resistor: ignore calibration, default trim
// - Burst length codes 4/8/16, default 4
// - Bit 4 picks wrap; no-wrap only BL4
// - Precharge starts write-recovery cycles after a write burst with auto-precharge
// - Column bit 0 not sent, taken zero
// - BL4 wrap orders 0123 or 2301
// - BL8 sequential modulo 8 or XOR
// - BL16 sequential modulo 16 only
// - No-wrap BL4 counts up from start
// - Controller avoids page-crossing no-wrap starts
// - Reserved bits read zero
// - Writes to info register ignored
// - Write-only reads give filler, strobe toggles
`timescale 1ns/100ps
module mib_dev (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic [1:0] cal_pin_sense,
   output logic factory_trim_used,
   output logic cal_busy,
   mib_link_if.dev link
);
   logic [15:0] init_cnt_q;
   logic [7:0] cal_cnt_q;
   logic cal_act_q;
   logic [1:0] rzq_q;
   logic ftrim_q;
   logic [7:0] cfg_q;
   logic mr_ack_q;
   logic [7:0] mr_rdata_q;
   logic dqs_q;
   logic [7:0] info;
   logic cal_locked, cal_go;
   logic [1:0] rzq_new;
   logic act_q, wr_q, ap_q, int_q, nw_q;
   logic [3:0] mask_q, beat_q, nwr_q, wr_cnt_q;
   logic [9:0] start_q, beat_col_q, col_d;
   logic [3:0] low;
   logic beat_valid_q, done_q, pre_q;
   logic [3:0] mask_d;

   // ****************************************
   // Auto-initialisation
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         init_cnt_q <= mib_pkg::AUTO_INIT_CYCLES;
      else if (init_cnt_q != 16'h0000)
         init_cnt_q <= init_cnt_q - 16'h0001;

   // ****************************************
   // Resistor self test
   // ****************************************
   always_comb
   begin
      cal_locked = rzq_q == mib_pkg::RZQ_SUPPLY_OR_FLOAT || rzq_q == mib_pkg::RZQ_GROUND;
      cal_go = link.mr_valid && link.mr_write && link.mr_addr == mib_pkg::MR_ADDR_CAL
               && !cal_act_q && !cal_locked;
      unique case (cal_pin_sense)
         mib_pkg::PIN_RESISTOR: rzq_new = mib_pkg::RZQ_PASSED;
         mib_pkg::PIN_SUPPLY: rzq_new = mib_pkg::RZQ_SUPPLY_OR_FLOAT;
         mib_pkg::PIN_FLOAT: rzq_new = mib_pkg::RZQ_SUPPLY_OR_FLOAT;
         mib_pkg::PIN_GROUND: rzq_new = mib_pkg::RZQ_GROUND;
      endcase
   end

   // Pin level is sampled only at the end, so a late assembly fix still counts
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         cal_act_q <= 1'h0;
         cal_cnt_q <= 8'h00;
         rzq_q <= mib_pkg::RZQ_NOT_RUN;
         ftrim_q <= 1'h0;
      end
      else if (cal_go)
      begin
         cal_act_q <= 1'h1;
         cal_cnt_q <= mib_pkg::CAL_CYCLES;
      end
      else if (cal_act_q)
      begin
         if (cal_cnt_q == 8'h01)
         begin
            cal_act_q <= 1'h0;
            rzq_q <= rzq_new;
            ftrim_q <= rzq_new != mib_pkg::RZQ_PASSED;
         end
         else
            cal_cnt_q <= cal_cnt_q - 8'h01;
      end

   assign factory_trim_used = ftrim_q;
   assign cal_busy = cal_act_q;

   // ****************************************
   // Mode register access
   // ****************************************
   assign info = {mib_pkg::INFO_RSVD, rzq_q, mib_pkg::INFO_DNV_NONE,
                  mib_pkg::INFO_TYPE_S4, init_cnt_q != 16'h0000};

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         mr_ack_q <= 1'h0;
         mr_rdata_q <= 8'h00;
         dqs_q <= 1'h0;
      end
      else
      begin
         mr_ack_q <= link.mr_valid;
         if (link.mr_valid && !link.mr_write)
         begin
            mr_rdata_q <= (link.mr_addr == mib_pkg::MR_ADDR_INFO) ? info : mib_pkg::UNDEF_RDATA;
            dqs_q <= !dqs_q;
         end
      end

   // Info register has no write path at all
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
         cfg_q <= mib_pkg::FEAT_RESET;
      else if (link.mr_valid && link.mr_write && link.mr_addr == mib_pkg::MR_ADDR_FEAT)
         cfg_q <= link.mr_wdata;

   assign link.mr_ack = mr_ack_q;
   assign link.mr_rdata = mr_rdata_q;
   assign link.dqs = dqs_q;

   // ****************************************
   // Burst ordering
   // ****************************************
   always_comb
   begin
      unique case (cfg_q[2:0])
         mib_pkg::BL8: mask_d = mib_pkg::MASK_BL8;
         mib_pkg::BL16: mask_d = mib_pkg::MASK_BL16;
         default: mask_d = mib_pkg::MASK_BL4; // Reserved codes fall back to 4
      endcase
      low = int_q ? (start_q[3:0] ^ beat_q) : 4'(start_q[3:0] + beat_q);
      if (nw_q)
         col_d = 10'(start_q + {6'h00, beat_q});
      else
         col_d = {start_q[9:4], (start_q[3:0] & ~mask_q) | (low & mask_q)};
   end

   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         act_q <= 1'h0;
         wr_q <= 1'h0;
         ap_q <= 1'h0;
         int_q <= 1'h0;
         nw_q <= 1'h0;
         mask_q <= mib_pkg::MASK_BL4;
         nwr_q <= 4'h0;
         start_q <= 10'h000;
         beat_q <= 4'h0;
         beat_col_q <= 10'h000;
         beat_valid_q <= 1'h0;
         done_q <= 1'h0;
      end
      else
      begin
         beat_valid_q <= act_q;
         done_q <= 1'h0;
         if (!act_q && link.col_valid)
         begin
            act_q <= 1'h1;
            start_q <= {link.col_addr, 1'h0};
            beat_q <= 4'h0;
            wr_q <= link.col_write;
            ap_q <= link.col_ap;
            mask_q <= mask_d;
            int_q <= cfg_q[3];
            nw_q <= cfg_q[4];
            nwr_q <= 4'({1'h0, cfg_q[7:5]} + mib_pkg::NWR_OFFSET);
         end
         else if (act_q)
         begin
            beat_col_q <= col_d;
            if (beat_q == mask_q)
            begin
               act_q <= 1'h0;
               done_q <= 1'h1;
            end
            else
               beat_q <= beat_q + 4'h1;
         end
      end

   // ****************************************
   // Write recovery before precharge
   // ****************************************
   always_ff @(posedge hclk or negedge hresetn)
      if (!hresetn)
      begin
         wr_cnt_q <= 4'h0;
         pre_q <= 1'h0;
      end
      else
      begin
         pre_q <= wr_cnt_q == 4'h1;
         if (act_q && beat_q == mask_q && wr_q && ap_q)
            wr_cnt_q <= nwr_q;
         else if (wr_cnt_q != 4'h0)
            wr_cnt_q <= wr_cnt_q - 4'h1;
      end

   assign link.beat_valid = beat_valid_q;
   assign link.beat_col = beat_col_q;
   assign link.burst_done = done_q;
   assign link.precharge_start = pre_q;
endmodule

// [sim/mib_assertions.sv]
`timescale 1ns/100ps
module mib_assertions (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic mr_valid,
   input wire logic mr_write,
   input wire logic [7:0] mr_addr,
   input wire logic mr_ack,
   input wire logic [7:0] mr_rdata,
   input wire logic dqs,
   input wire logic col_valid,
   input wire logic [9:1] col_addr,
   input wire logic beat_valid,
   input wire logic [9:0] beat_col,
   input wire logic burst_done,
   input wire logic precharge_start
);
   // ****************************************
   // Link checks
   // ****************************************
   default clocking cb @(posedge hclk);
   endclocking
   default disable iff (!hresetn);

   property p_ack_follows;
      mr_valid |=> mr_ack;
   endproperty
   a_ack_follows: assert property (p_ack_follows) else $error("mode command not acknowledged");

   property p_ack_cause;
      mr_ack |-> $past(mr_valid);
   endproperty
   a_ack_cause: assert property (p_ack_cause) else $error("acknowledge without command");

   property p_info_bits;
      mr_valid && !mr_write && mr_addr == mib_pkg::MR_ADDR_INFO |=> mr_rdata[7:5] == mib_pkg::INFO_RSVD
         && mr_rdata[2] == mib_pkg::INFO_DNV_NONE && mr_rdata[1] == mib_pkg::INFO_TYPE_S4;
   endproperty
   a_info_bits: assert property (p_info_bits) else $error("fixed info bits wrong");

   property p_filler;
      mr_valid && !mr_write && mr_addr == mib_pkg::MR_ADDR_FEAT |=> mr_rdata == mib_pkg::UNDEF_RDATA
         && dqs != $past(dqs);
   endproperty
   a_filler: assert property (p_filler) else $error("write-only read gave wrong data or no strobe");

   property p_first_beat;
      col_valid |-> ##2 beat_valid && beat_col == {$past(col_addr, 2), 1'b0};
   endproperty
   a_first_beat: assert property (p_first_beat) else $error("first beat column or timing wrong");

   property p_last_beat;
      burst_done |-> beat_valid ##1 !beat_valid;
   endproperty
   a_last_beat: assert property (p_last_beat) else $error("burst end not on last beat");

   property p_beats_joined;
      beat_valid && !burst_done |=> beat_valid;
   endproperty
   a_beats_joined: assert property (p_beats_joined) else $error("gap inside burst");

   // Recovery is at least three cycles, so two idle cycles always precede the pulse
   property p_recovery;
      precharge_start |-> !$past(beat_valid) && !$past(beat_valid, 2);
   endproperty
   a_recovery: assert property (p_recovery) else $error("precharge too close to last beat");
endmodule

// [sim/mode_info_and_burst_order_test.sv]
`timescale 1ns/100ps
module mode_info_and_burst_order_test;
   logic hclk = 1'b0;
   logic hresetn = 1'b0;
   logic hsel = 1'b0;
   logic [31:0] haddr = 32'h0000_0000;
   logic [1:0] htrans = 2'h0;
   logic hwrite = 1'b0;
   logic [31:0] hwdata = 32'h0000_0000;
   logic [1:0] cal_pin_sense = 2'h0;
   logic hreadyout;
   logic [31:0] hrdata;
   logic hresp;
   logic factory_trim_used;
   logic cal_busy;
   logic [31:0] rd;
   logic [7:0] v;
   logic [9:0] beats[$];
   int gap = 0;
   int pc_gap = 0;
   int errors = 0;
   int tests_run = 0;
   logic [31:0] bad[4];
   int twr_ns[4] = '{25, 40, 45, 80};
   logic [1:0] res_of_pin[4];

   always #5 hclk = ~hclk;

   mib_link_if mib_link_if_inst ();
   mib_ctl mib_ctl_inst (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hrdata(hrdata), .hresp(hresp), .link(mib_link_if_inst));
   mib_dev mib_dev_inst (.hclk(hclk), .hresetn(hresetn), .cal_pin_sense(cal_pin_sense),
      .factory_trim_used(factory_trim_used), .cal_busy(cal_busy), .link(mib_link_if_inst));
   mib_assertions mib_assertions_inst (.hclk(hclk), .hresetn(hresetn), .mr_valid(mib_link_if_inst.mr_valid),
      .mr_write(mib_link_if_inst.mr_write), .mr_addr(mib_link_if_inst.mr_addr), .mr_ack(mib_link_if_inst.mr_ack),
      .mr_rdata(mib_link_if_inst.mr_rdata), .dqs(mib_link_if_inst.dqs), .col_valid(mib_link_if_inst.col_valid),
      .col_addr(mib_link_if_inst.col_addr), .beat_valid(mib_link_if_inst.beat_valid),
      .beat_col(mib_link_if_inst.beat_col), .burst_done(mib_link_if_inst.burst_done),
      .precharge_start(mib_link_if_inst.precharge_start));

   // ****************************************
   // Beat and precharge monitor
   // ****************************************
   always @(posedge hclk)
   begin
      if (mib_link_if_inst.beat_valid === 1'b1)
         gap = 0;
      else
         gap = gap + 1;
      if (mib_link_if_inst.precharge_start === 1'b1)
         pc_gap = gap;
      if (mib_link_if_inst.beat_valid === 1'b1)
         beats.push_back(mib_link_if_inst.beat_col);
   end

   // ****************************************
   // Bus tasks
   // ****************************************
   task finish_test;
      if (errors == 0 && tests_run > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
      tests_run++;
      if (seen !== exp)
      begin
         errors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task ahb(input logic wr, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
      @(posedge hclk);
      hsel <= 1'b1;
      haddr <= {28'h000_0000, a};
      htrans <= 2'h2;
      hwrite <= wr;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      r = hrdata;
   endtask

   // Polls until the controller drops busy; the watchdog bounds a hang
   task wait_idle(output logic [31:0] s);
      do ahb(1'b0, mib_pkg::REG_STATUS, 32'h0000_0000, s); while (s[8] !== 1'b0);
   endtask

   task mr(input logic wr_en, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
      ahb(1'b1, mib_pkg::REG_MR_CMD, {15'h0000, wr_en, d, a}, rd);
      wait_idle(rd);
      r = rd[7:0];
   endtask

   function automatic logic [31:0] feat(logic [2:0] bl, logic it, logic nw, logic [7:0] ns);
      return {16'h0000, ns, 3'h0, nw, it, bl};
   endfunction

   // Zero feature word keeps the current burst setup
   task burst(input logic [31:0] f, input logic [11:0] c, input int n, input logic nw, input logic it);
      logic [9:0] mask;
      logic [9:0] start;
      logic [9:0] e;
      if (f !== 32'h0000_0000)
      begin
         ahb(1'b1, mib_pkg::REG_FEATURE, f, rd);
         wait_idle(rd);
      end
      beats.delete();
      start = {c[9:1], 1'b0};
      mask = 10'(n - 1);
      ahb(1'b1, mib_pkg::REG_BURST, {20'h0_0000, c}, rd);
      wait_idle(rd);
      check("beat count", 32'(beats.size()), 32'(n));
      for (int i = 0; i < n; i++)
      begin
         if (nw)
            e = start + 10'(i);
         else if (it)
            e = (start & ~mask) | ((start & mask) ^ 10'(i));
         else
            e = (start & ~mask) | ((start + 10'(i)) & mask);
         check("beat column", {22'h00_0000, beats[i]}, {22'h00_0000, e});
      end
   endtask

   task do_reset;
      hresetn <= 1'b0;
      repeat (20) @(posedge hclk);
      hresetn <= 1'b1;
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial
   begin
      repeat (30000) @(posedge hclk);
      errors++;
      finish_test;
   end

   initial
   begin
      bad = '{feat(3'h7, 0, 0, 30), feat(mib_pkg::BL8, 0, 1, 30), feat(mib_pkg::BL16, 1, 0, 30), feat(3'h2, 0, 0, 90)};
      res_of_pin = '{mib_pkg::RZQ_PASSED, mib_pkg::RZQ_SUPPLY_OR_FLOAT, mib_pkg::RZQ_SUPPLY_OR_FLOAT,
         mib_pkg::RZQ_GROUND};
      do_reset;
      mr(1'b0, mib_pkg::MR_ADDR_INFO, 8'h00, v);
      check("info during init", {24'h00_0000, v}, 32'h0000_0001);
      burst(32'h0000_0000, 12'h006, 4, 1'b0, 1'b0);
      repeat (100) @(posedge hclk);
      mr(1'b0, mib_pkg::MR_ADDR_INFO, 8'h00, v);
      check("info after init", {24'h00_0000, v}, 32'h0000_0000);
      mr(1'b1, mib_pkg::MR_ADDR_INFO, 8'hFF, v);
      mr(1'b0, mib_pkg::MR_ADDR_INFO, 8'h00, v);
      check("info after write", {24'h00_0000, v}, 32'h0000_0000);
      mr(1'b0, mib_pkg::MR_ADDR_FEAT, 8'h00, v);
      check("feature read", {24'h00_0000, v}, {24'h00_0000, mib_pkg::UNDEF_RDATA});
      ahb(1'b0, mib_pkg::REG_BURST, 32'h0000_0000, rd);
      check("unmapped read", rd, mib_pkg::WORD_ZERO);
      check("bus response", {31'h0000_0000, hresp}, 32'h0000_0000);
      burst(feat(mib_pkg::BL4, 1, 0, 30), 12'h00E, 4, 1'b0, 1'b1);
      burst(feat(mib_pkg::BL4, 0, 0, 30), 12'h005, 4, 1'b0, 1'b0);
      burst(feat(mib_pkg::BL8, 0, 0, 30), 12'h00A, 8, 1'b0, 1'b0);
      burst(feat(mib_pkg::BL8, 1, 0, 30), 12'h006, 8, 1'b0, 1'b1);
      burst(feat(mib_pkg::BL16, 0, 0, 30), 12'h3F6, 16, 1'b0, 1'b0);
      burst(feat(mib_pkg::BL4, 0, 1, 30), 12'h1FA, 4, 1'b1, 1'b0);
      burst(feat(mib_pkg::BL4, 1, 1, 30), 12'h03E, 4, 1'b1, 1'b1);
      foreach (bad[i])
      begin
         ahb(1'b1, mib_pkg::REG_FEATURE, bad[i], rd);
         wait_idle(rd);
         check("refused feature", {31'h0000_0000, rd[9]}, 32'h0000_0001);
         ahb(1'b1, mib_pkg::REG_STATUS, 32'h0000_0000, rd);
      end
      beats.delete();
      ahb(1'b1, mib_pkg::REG_BURST, {22'h00_0000, mib_pkg::COL_FULL_X16}, rd);
      wait_idle(rd);
      check("refused start", {31'h0000_0000, rd[9]}, 32'h0000_0001);
      check("refused beats", 32'(beats.size()), 32'h0000_0000);
      ahb(1'b1, mib_pkg::REG_STATUS, 32'h0000_0000, rd);
      beats.delete();
      ahb(1'b1, mib_pkg::REG_BURST, {22'h00_0000, mib_pkg::COL_SUB_X16 | 10'h001}, rd);
      wait_idle(rd);
      check("refused odd start", {31'h0000_0000, rd[9]}, 32'h0000_0001);
      check("refused odd beats", 32'(beats.size()), 32'h0000_0000);
      ahb(1'b1, mib_pkg::REG_STATUS, 32'h0000_0000, rd);
      burst(32'h0000_0000, 12'h010, 4, 1'b1, 1'b1);
      foreach (twr_ns[i])
      begin
         pc_gap = 0;
         burst(feat(mib_pkg::BL4, 0, 0, 8'(twr_ns[i])), 12'hC00, 4, 1'b0, 1'b0);
         repeat (12) @(posedge hclk);
         check("write recovery", 32'(pc_gap), 32'(twr_ns[i] < 30 ? 3 : (twr_ns[i] + 9) / 10));
      end
      for (int p = 0; p < 4; p++)
      begin
         do_reset;
         cal_pin_sense <= 2'(p);
         mr(1'b1, mib_pkg::MR_ADDR_CAL, 8'h00, v);
         check("cal running", {31'h0000_0000, cal_busy}, 32'h0000_0001);
         repeat (45) @(posedge hclk);
         mr(1'b0, mib_pkg::MR_ADDR_INFO, 8'h00, v);
         check("self test", {30'h0000_0000, v[4:3]}, {30'h0000_0000, res_of_pin[p]});
         check("factory trim", {31'h0000_0000, factory_trim_used}, 32'(p != 0));
         cal_pin_sense <= (p == 0) ? mib_pkg::PIN_GROUND : mib_pkg::PIN_RESISTOR;
         mr(1'b1, mib_pkg::MR_ADDR_CAL, 8'h00, v);
         repeat (45) @(posedge hclk);
         mr(1'b0, mib_pkg::MR_ADDR_INFO, 8'h00, v);
         check("second test", {30'h0000_0000, v[4:3]}, (p == 0) ? 32'h0000_0002 : {30'h0000_0000, res_of_pin[p]});
      end
      finish_test;
   end
endmodule
